// File: hw/bmx_byte_move.sv
/*
  Byte move executor: register file, flags register and a small engine
  that carries out one byte transfer per command.
  Assumes an Avalon-MM master on the register side and a memory port
  that acknowledges each request with a one-cycle ack.
*/
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
// Functional notes
// - Eight wide registers, sixteen halves, sixteen bytes
// - Memory base is a full wide register
// - Post-increment load reads, then adds one
// - Pre-decrement store subtracts one, then writes
// - Negative flag copies transferred bit seven
// - Zero flag set when transferred byte zero
// - Overflow flag cleared by every move
// - Carry and other flag bits unchanged
`timescale 1ns/10ps
module bmx_byte_move
  import bmx_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]   avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic      [31:0]  avs_readdata_o,
  output logic              avs_waitrequest_o,
  // Memory port
  output bmx_mem_req_t      mem_o,
  input  wire logic [7:0]   mem_rdata_i,
  input  wire logic         mem_ack_i
);

  // ----------------------------------------------------------------
  // Byte helpers
  // ----------------------------------------------------------------
  // Low selects bits 7:0, otherwise bits 15:8
  function automatic logic [7:0] byte_get(input logic [31:0] r,
                                          input logic lo);
    return lo ? r[7:0] : r[15:8];
  endfunction : byte_get

  function automatic logic [31:0] byte_put(input logic [31:0] r,
                                           input logic lo,
                                           input logic [7:0] b);
    return lo ? {r[31:8], b} : {r[31:16], b, r[7:0]};
  endfunction : byte_put

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]  gpr_ff [8];      // Wide registers
  logic [31:0]  nxt_gpr [8];
  logic [7:0]   flags_ff;        // Flags register
  logic [7:0]   nxt_flags;
  logic [31:0]  disp_ff;         // Displacement or absolute address
  logic [31:0]  nxt_disp;
  bmx_cmd_t     cmd_ff;          // Latched command
  bmx_state_t   state_ff;
  bmx_state_t   nxt_state;
  logic [31:0]  ea_ff;           // Effective address
  logic [7:0]   wdata_ff;        // Store data
  logic         done_ff;         // Sticky completion
  logic         resp_ff;         // Bus answer cycle
  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic       busy     = (state_ff != ST_IDLE);
  // Writes wait while busy so software never races the engine
  wire logic       accept   = (avs_read_i | (avs_write_i & ~busy))
                              & ~resp_ff;
  wire logic       bus_wr   = avs_write_i & resp_ff;
  wire logic [7:0] ba       = avs_address_i;
  wire logic       hit_gpr  = (ba & MSK_GPR) == ADR_GPR0;
  wire logic       hit_half = (ba & MSK_WIN) == ADR_HALF0;
  wire logic       hit_byte = (ba & MSK_WIN) == ADR_BYTE0;
  wire logic       hit_flg  = ba == ADR_FLAGS;
  wire logic       hit_cmd  = ba == ADR_CMD;
  wire logic       hit_disp = ba == ADR_DISP;
  wire logic       hit_stat = ba == ADR_STAT;
  wire logic [2:0] widx     = ba[4:2];  // Wide register index
  wire logic [3:0] sidx     = ba[5:2];  // Half or byte index
  wire logic       cmd_wr   = bus_wr & hit_cmd;
  wire logic [31:0] be_mask = {{8{avs_byteenable_i[3]}},
                               {8{avs_byteenable_i[2]}},
                               {8{avs_byteenable_i[1]}},
                               {8{avs_byteenable_i[0]}}};

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_ff;
  assign avs_readdata_o    = rdata_ff;

  // Read selection; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_gpr) begin
      nxt_rdata = gpr_ff[widx];
    end else if (hit_half) begin
      nxt_rdata[15:0] = sidx[3] ? gpr_ff[sidx[2:0]][31:16]
                                : gpr_ff[sidx[2:0]][15:0];
    end else if (hit_byte) begin
      nxt_rdata[7:0] = byte_get(gpr_ff[sidx[2:0]], sidx[3]);
    end else if (hit_flg) begin
      nxt_rdata[7:0] = flags_ff;
    end else if (hit_cmd) begin
      nxt_rdata = cmd_ff;
    end else if (hit_disp) begin
      nxt_rdata = disp_ff;
    end else if (hit_stat) begin
      nxt_rdata[STA_BUSY] = busy;
      nxt_rdata[STA_DONE] = done_ff;
    end
  end

  // ----------------------------------------------------------------
  // Engine decode
  // ----------------------------------------------------------------
  wire bmx_mode_t  md       = cmd_ff.mode;
  wire logic       st_exec  = (state_ff == ST_EXEC);
  wire logic       st_mem   = (state_ff == ST_MEM);
  wire logic       is_store = md inside {MD_ST_IND, MD_ST_DISP,
                                         MD_ST_PRE, MD_ST_ABS};
  wire logic       is_local = md inside {MD_IMM, MD_REG};
  wire logic [2:0] dst_reg  = cmd_ff.dst[2:0];
  wire logic [2:0] src_reg  = cmd_ff.src[2:0];
  // Base is always the whole wide register, never a half or byte
  wire logic [31:0] base_addr = gpr_ff[cmd_ff.areg];
  wire logic [7:0]  src_byte  = byte_get(gpr_ff[src_reg], cmd_ff.src[3]);
  wire logic       pre_step  = st_exec & (md == MD_ST_PRE);
  wire logic       mem_done  = st_mem & mem_ack_i;
  wire logic       post_step = mem_done & (md == MD_LD_POST);
  wire logic       xfer_done = (st_exec & is_local) | mem_done;
  wire logic       byte_wr   = xfer_done & ~is_store;
  wire logic [7:0] xfer_byte = is_store ? wdata_ff :
                               st_mem ? mem_rdata_i :
                               (md == MD_IMM) ? cmd_ff.imm : src_byte;
  wire logic       xfer_msb  = xfer_byte[7];
  wire logic       xfer_zero = (xfer_byte == 8'h00);
  logic [31:0]     ea_calc;

  // Effective address for each memory mode
  always_comb begin
    ea_calc = base_addr;
    case (md)
      MD_LD_DISP, MD_ST_DISP: ea_calc = base_addr + disp_ff;
      MD_LD_ABS,  MD_ST_ABS:  ea_calc = disp_ff;
      MD_ST_PRE:              ea_calc = base_addr - ONE32;
      default:                ea_calc = base_addr;
    endcase
  end

  // State sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (cmd_wr) nxt_state = ST_EXEC;
      ST_EXEC: nxt_state = is_local ? ST_IDLE : ST_MEM;
      ST_MEM:  if (mem_ack_i) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file next value
  // ----------------------------------------------------------------
  // Bus writes happen only while idle, engine writes only while busy
  always_comb begin
    nxt_gpr   = gpr_ff;
    nxt_flags = flags_ff;
    nxt_disp  = disp_ff;
    if (bus_wr) begin
      if (hit_gpr) begin
        nxt_gpr[widx] = (gpr_ff[widx] & ~be_mask)
                        | (avs_writedata_i & be_mask);
      end else if (hit_half && avs_byteenable_i[0]) begin
        nxt_gpr[sidx[2:0]] = sidx[3]
          ? {avs_writedata_i[15:0], gpr_ff[sidx[2:0]][15:0]}
          : {gpr_ff[sidx[2:0]][31:16], avs_writedata_i[15:0]};
      end else if (hit_byte && avs_byteenable_i[0]) begin
        nxt_gpr[sidx[2:0]] = byte_put(gpr_ff[sidx[2:0]], sidx[3],
                                      avs_writedata_i[7:0]);
      end else if (hit_flg && avs_byteenable_i[0]) begin
        nxt_flags = avs_writedata_i[7:0];
      end else if (hit_disp) begin
        nxt_disp = (disp_ff & ~be_mask) | (avs_writedata_i & be_mask);
      end
    end
    // Only the selected eight bits of the parent change
    if (byte_wr) begin
      nxt_gpr[dst_reg] = byte_put(gpr_ff[dst_reg], cmd_ff.dst[3],
                                  xfer_byte);
    end
    // Decrement lands before the store is issued
    if (pre_step) begin
      nxt_gpr[cmd_ff.areg] = ea_calc;
    end
    // Increment after the read; wins over a load into the same register
    if (post_step) begin
      nxt_gpr[cmd_ff.areg] = ea_ff + ONE32;
    end
    if (xfer_done) begin
      nxt_flags[FLG_N] = xfer_msb;
      nxt_flags[FLG_Z] = xfer_zero;
      nxt_flags[FLG_V] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  // Register file and flags
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      gpr_ff   <= '{default: GPR_RST};
      flags_ff <= FLAGS_RST;
      disp_ff  <= GPR_RST;
    end else begin
      gpr_ff   <= nxt_gpr;
      flags_ff <= nxt_flags;
      disp_ff  <= nxt_disp;
    end
  end

  // Bus answer: one wait state once accepted, read data captured at acceptance
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      resp_ff  <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      resp_ff  <= accept;
      rdata_ff <= accept ? nxt_rdata : rdata_ff;
    end
  end

  // Engine registers
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      cmd_ff   <= '0;
      ea_ff    <= GPR_RST;
      wdata_ff <= 8'h00;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff   <= cmd_wr ? bmx_cmd_t'(avs_writedata_i) : cmd_ff;
      ea_ff    <= st_exec ? ea_calc : ea_ff;
      wdata_ff <= st_exec ? src_byte : wdata_ff;
      // Completion sets, a new command clears; never the same cycle
      done_ff  <= xfer_done | (done_ff & ~cmd_wr);
    end
  end

  // Memory request held from the address cycle until ack
  assign mem_o = '{req: st_mem, we: is_store, addr: ea_ff,
                   wdata: wdata_ff};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_pre_step;
    pre_step ##1 st_mem;
  endsequence
  sequence s_post_read;
    post_step;
  endsequence
  chk_flag_neg: assert property (xfer_done |=>
    flags_ff[FLG_N] == $past(xfer_msb)) else $error("negative flag wrong");
  chk_flag_zero: assert property (xfer_done |=>
    flags_ff[FLG_Z] == $past(xfer_zero)) else $error("zero flag wrong");
  chk_flag_ovf: assert property (xfer_done |=>
    !flags_ff[FLG_V]) else $error("overflow flag not cleared");
  chk_flag_keep: assert property (xfer_done |=>
    (flags_ff & FLG_KEEP) == ($past(flags_ff) & FLG_KEEP))
    else $error("untouched flag bits changed");
  chk_post_inc: assert property (s_post_read |=>
    gpr_ff[cmd_ff.areg] == $past(ea_ff) + ONE32)
    else $error("post-increment wrong");
  chk_pre_dec: assert property (s_pre_step |->
    mem_o.addr == gpr_ff[cmd_ff.areg] && mem_o.we &&
    mem_o.addr == $past(base_addr) - ONE32)
    else $error("pre-decrement store address wrong");
  chk_base_full: assert property (
    st_exec && md == MD_LD_IND |=> mem_o.req && mem_o.addr == $past(base_addr))
    else $error("indirect base not full register");
  chk_byte_keep: assert property (
    byte_wr && !post_step && cmd_ff.dst[3] |=>
    gpr_ff[$past(dst_reg)][31:8] == $past(gpr_ff[dst_reg][31:8]))
    else $error("byte write disturbed other bits");
  chk_bus_answer: assert property (
    avs_read_i && !resp_ff |=> !avs_waitrequest_o)
    else $error("read not answered in one wait state");
endmodule : bmx_byte_move

// File: shared/bmx_pkg.sv
/*
  Constants, modes, states and carriers for the byte move executor.
  Assumes a 32-bit Avalon-MM register bus with byte addresses and one
  byte-wide memory port toward the core's memory and peripheral bus.
*/
package bmx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_GPR0   = 8'h00; // Eight wide registers
  localparam logic [7:0] ADR_FLAGS  = 8'h20; // Flags register
  localparam logic [7:0] ADR_CMD    = 8'h24; // Command, write starts
  localparam logic [7:0] ADR_DISP   = 8'h28; // Displacement or address
  localparam logic [7:0] ADR_STAT   = 8'h2C; // Busy and done
  localparam logic [7:0] ADR_HALF0  = 8'h40; // Sixteen 16-bit halves
  localparam logic [7:0] ADR_BYTE0  = 8'h80; // Sixteen byte registers
  localparam logic [7:0] MSK_GPR    = 8'hE0; // Window masks
  localparam logic [7:0] MSK_WIN    = 8'hC0;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLG_N     = 3;     // Negative flag
  localparam int unsigned FLG_Z     = 2;     // Zero flag
  localparam int unsigned FLG_V     = 1;     // Overflow flag
  localparam logic [7:0]  FLG_KEEP  = 8'hF1; // Bits a move never touches
  localparam int unsigned STA_BUSY  = 0;
  localparam int unsigned STA_DONE  = 1;
  localparam logic [31:0] GPR_RST   = 32'h0000_0000;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [31:0] ONE32     = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Transfer modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MD_IMM     = 4'h0, // Immediate to byte register
    MD_REG     = 4'h1, // Byte register to byte register
    MD_LD_IND  = 4'h2, // Load from address register
    MD_LD_DISP = 4'h3, // Load from address register plus displacement
    MD_LD_POST = 4'h4, // Load, then address register plus one
    MD_LD_ABS  = 4'h5, // Load from absolute address
    MD_ST_IND  = 4'h6, // Store to address register
    MD_ST_DISP = 4'h7, // Store to address register plus displacement
    MD_ST_PRE  = 4'h8, // Address register minus one, then store
    MD_ST_ABS  = 4'h9  // Store to absolute address
  } bmx_mode_t;

  // Engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_MEM  = 3'b100
  } bmx_state_t;

  // Command word layout
  typedef struct packed {
    logic [7:0] rsv_hi;
    bmx_mode_t  mode;
    logic       rsv_lo;
    logic [2:0] areg;  // Address register index
    logic [3:0] dst;   // Byte register: bit 3 low half, 2:0 parent
    logic [3:0] src;
    logic [7:0] imm;
  } bmx_cmd_t;

  // Memory request carrier
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } bmx_mem_req_t;

endpackage : bmx_pkg

// File: tb/bmx_byte_move_test.sv
/*
  Self-checking bench for the byte move executor.
  Assumes bmx_pkg, the executor and the memory model are compiled first.
*/
`timescale 1ns/10ps
module bmx_byte_move_test
  import bmx_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         clk;       // System clock
  logic         rst_n;     // Reset, active low
  logic [7:0]   adr;       // Bus address
  logic         rd;        // Bus read
  logic         wr;        // Bus write
  logic [31:0]  wd;        // Bus write data
  logic [3:0]   be;        // Bus byte lanes
  logic [31:0]  rdat;      // Bus read data
  logic         wreq;      // Bus wait request
  bmx_mem_req_t mreq;      // Memory request
  logic [7:0]   mrd;       // Memory read data
  logic         mack;      // Memory acknowledge
  logic [1:0]   lag;       // Memory answer delay
  logic [31:0]  seen;      // Last address answered
  logic [31:0]  q;         // Last bus read result
  int           failures;  // Mismatches
  int           tests_run; // Comparisons
  bmx_mode_t    sm [3] = '{MD_ST_IND, MD_ST_DISP, MD_ST_ABS};
  logic [31:0]  sa [3] = '{32'h0001_0020, 32'h0001_00C5, 32'h0000_00A5};

  bmx_byte_move uut (.ref_clk_i(clk), .reset_n_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .mem_o(mreq), .mem_rdata_i(mrd),
    .mem_ack_i(mack));
  bmx_mem_model mem (.clk_i(clk), .reset_n_i(rst_n), .mem_i(mreq),
    .lag_i(lag), .rdata_o(mrd), .ack_o(mack), .addr_seen_o(seen));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    be <= b;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 200);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 200) failures++;
    @(posedge clk);
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : w

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(nm, e, q);
  endtask : rc

  // Start a command, then poll until done; bounded so a hang shows
  task automatic run(input bmx_mode_t m, input logic [2:0] ar,
                     input logic [3:0] d, input logic [3:0] s,
                     input logic [7:0] i);
    int n;
    n = 0;
    w(ADR_CMD, {8'h00, m, 1'b0, ar, d, s, i});
    do begin
      bus(1'b0, ADR_STAT, 32'h0000_0000, 4'hF);
      n++;
    end while (q[STA_DONE] !== 1'b1 && n < 50);
    if (n >= 50) failures++;
  endtask : run

  task automatic complete_run;
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    be = 4'hF;
    lag = 2'h0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("flags reset", ADR_FLAGS, 32'h0000_0000);
    // Views of one wide register, then byte lanes of register six
    w(8'h00, 32'h1122_3344);
    rc("half8", 8'h60, 32'h0000_1122);
    rc("byte0", 8'h80, 32'h0000_0033);
    rc("byte8", 8'hA0, 32'h0000_0044);
    w(8'hA0, 32'h0000_00FF);
    rc("reg0", 8'h00, 32'h1122_33FF);
    w(8'h60, 32'h0000_5566);
    rc("reg0 half", 8'h00, 32'h5566_33FF);
    bus(1'b1, 8'h18, 32'hAAAA_AAAA, 4'h2);
    rc("reg6 lanes", 8'h18, 32'h0000_AA00);
    // Flags from register moves; kept bits and carry set beforehand
    w(ADR_FLAGS, 32'h0000_00F3);
    run(MD_IMM, 3'h0, 4'h1, 4'h0, 8'h00);
    rc("flags zero", ADR_FLAGS, 32'h0000_00F5);
    rc("stat idle", ADR_STAT, 32'h0000_0002);
    run(MD_IMM, 3'h0, 4'h1, 4'h0, 8'h80);
    rc("flags neg", ADR_FLAGS, 32'h0000_00F9);
    run(MD_REG, 3'h0, 4'h9, 4'h1, 8'h00);
    rc("reg1", 8'h04, 32'h0000_8080);
    // Pre-decrement store then post-increment load, slow memory
    lag <= 2'h2;
    w(8'h08, 32'h0000_0010);
    run(MD_ST_PRE, 3'h2, 4'h0, 4'h1, 8'h00);
    rc("reg2 dec", 8'h08, 32'h0000_000F);
    chk("st addr", 32'h0000_000F, seen);
    w(ADR_FLAGS, 32'h0000_00F3);
    run(MD_LD_POST, 3'h2, 4'hB, 4'h0, 8'h00);
    chk("ld addr", 32'h0000_000F, seen);
    rc("byte11", 8'hAC, 32'h0000_0080);
    rc("reg2 inc", 8'h08, 32'h0000_0010);
    rc("flags ld", ADR_FLAGS, 32'h0000_00F9);
    // Full wide base, displacement and absolute loads
    lag <= 2'h0;
    w(8'h10, 32'h0001_0020);
    run(MD_LD_IND, 3'h4, 4'hD, 4'h0, 8'h00);
    chk("ind addr", 32'h0001_0020, seen);
    rc("byte13 ind", 8'hB4, 32'h0000_0085);
    w(ADR_DISP, 32'hFFFF_FFFF);
    run(MD_LD_DISP, 3'h4, 4'hD, 4'h0, 8'h00);
    chk("disp addr", 32'h0001_001F, seen);
    rc("byte13 disp", 8'hB4, 32'h0000_00BA);
    w(ADR_DISP, 32'h0000_00A5);
    run(MD_LD_ABS, 3'h0, 4'hD, 4'h0, 8'h00);
    rc("byte13 abs", 8'hB4, 32'h0000_0000);
    rc("flags abs", ADR_FLAGS, 32'h0000_00F5);
    // Each remaining store form
    foreach (sm[k]) begin
      run(sm[k], 3'h4, 4'h0, 4'h1, 8'h00);
      chk("st form addr", sa[k], seen);
      rc("flags st", ADR_FLAGS, 32'h0000_00F9);
    end
    run(MD_LD_ABS, 3'h0, 4'hD, 4'h0, 8'h00);
    rc("abs readback", 8'hB4, 32'h0000_0080);
    rc("unmapped", 8'h30, 32'h0000_0000);
    complete_run();
  end

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule : bmx_byte_move_test

// File: tb/bmx_mem_model.sv
/*
  Behavioural model of the core's memory and peripheral bus.
  Assumes requests from the byte move executor that hold until a one-cycle
  acknowledge; only the low eight address bits select a stored byte.
*/
`timescale 1ns/10ps
module bmx_mem_model
  import bmx_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // Request and answer
  input  wire bmx_mem_req_t mem_i,
  input  wire logic [1:0]   lag_i,
  output logic      [7:0]   rdata_o,
  output logic              ack_o,
  output logic      [31:0]  addr_seen_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_ff [256]; // Byte store
  logic [1:0] wait_ff;      // Cycles spent on this request

  // Answer after lag_i cycles; data toggles outside the ack so stale
  // bytes never look valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!reset_n_i) begin
      wait_ff <= 2'h0;
      rdata_o <= 8'h00;
      addr_seen_o <= 32'h0000_0000;
      // Known, varied contents so loads give distinct bytes
      for (int i = 0; i < 256; i++) mem_ff[i] <= 8'(i) ^ 8'hA5;
    end else if (mem_i.req && !ack_o) begin
      if (wait_ff == lag_i) begin
        ack_o <= 1'b1;
        wait_ff <= 2'h0;
        addr_seen_o <= mem_i.addr;
        rdata_o <= mem_i.we ? ~mem_i.wdata : mem_ff[mem_i.addr[7:0]];
        if (mem_i.we) mem_ff[mem_i.addr[7:0]] <= mem_i.wdata;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule : bmx_mem_model
